// *** hdl/ppg_rate_defs.vh ***
`ifndef PPG_RATE_DEFS_VH
`define PPG_RATE_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_EDGE_TIMING_RATE 12'h000
`define OFS_PHASE_SHIFT      12'h004
`define OFS_MOD_CYCLE_SEL    12'h008
`define OFS_WAVE_STATUS      12'h00c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RATE_LSB        0
`define RATE_MSB        3
`define TIMING_LSB      4
`define TIMING_MSB      19
`define BIT31           31
`define PHASE_LSB       1
`define PHASE_MSB       16
`define CYC_A_LSB       0
`define CYC_A_MSB       2
`define CYC_B_LSB       4
`define CYC_B_MSB       6
`define CYC_SEL_BIT     8

// ----------------------------------------------------------------------
// Reset values and cycle codes
// ----------------------------------------------------------------------
`define RST_EDGE_TIMING_RATE 32'h0000_0000
`define RST_PHASE_SHIFT      32'h0000_0000
`define RST_MOD_CYCLE_SEL    32'h0000_0000
`define CYC_NONE 3'h0
`define CYC_2    3'h1
`define CYC_4    3'h2
`define CYC_8    3'h3
`define CYC_16   3'h4

`endif

// *** hdl/ppg_timing_rate.v ***
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ppg_rate_defs.vh"

// Function
// - 4-bit modulation rate sits in bits 3:0, read and write.
// - Rate applies to second output in plain and interlocked PPG modes.
// - Effective rate bits follow the second output's cycle selection.
// - 000 none, 001 bit3, 010 bits3:2, 011 bits3:1, 100 all four.
// - Per modulation cycle, stretch that many waves by one clock.

module ppg_timing_rate (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire wave_end,
  input wire interlock_mode,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [15:0] second_output_edge_timing,
  output reg [15:0] phase_shift_amount,
  output reg edge_delay
);
  reg [3:0] rate;
  reg bit31;
  reg [15:0] phase;
  reg [2:0] modulation_cycle_select_a;
  reg [2:0] modulation_cycle_select_b;
  reg cycle_sel_use_b;
  reg [3:0] wave_index;
  wire [2:0] cycle_sel;
  wire [3:0] eff_rate;
  wire [3:0] cycle_last;
  wire stretch;
  wire setup;
  reg [31:0] next_rdata;
  reg next_err;
  // Decoded write strobes and wave bookkeeping
  reg [3:0] next_wave_index;
  reg wr_timing;
  reg wr_phase;
  reg wr_cycle;
  wire wr_access;
  wire rd_setup;
  wire cycle_wrap;

  // --------------------------------------------------------------------
  // Cycle selection and stretch decision
  // --------------------------------------------------------------------
  // Select between the two cycle fields for the second output
  assign cycle_sel = cycle_sel_use_b ? modulation_cycle_select_b :
                     modulation_cycle_select_a;
  assign setup = psel & ~penable;
  // Reads are picked up in setup so data stands for the access edge
  assign rd_setup = setup & ~pwrite;

  rate_spreader rate_spreader_inst (
    .cycle_sel(cycle_sel),
    .rate(rate),
    .wave_index(wave_index),
    .eff_rate(eff_rate),
    .cycle_last(cycle_last),
    .stretch(stretch)
  );

  // --------------------------------------------------------------------
  // APB register write
  // --------------------------------------------------------------------
  // Only the completing access edge writes; gating with pready keeps a
  // master that lingers in the access phase from writing twice
  assign wr_access = psel & penable & pready & pwrite;

  // One strobe per writable register; unmapped addresses strobe nothing
  always @* begin
    wr_timing = 1'b0;
    wr_phase = 1'b0;
    wr_cycle = 1'b0;
    if (!wr_access) begin
      wr_timing = 1'b0;
    end else if (paddr == `OFS_EDGE_TIMING_RATE) begin
      wr_timing = 1'b1;
    end else if (paddr == `OFS_PHASE_SHIFT) begin
      wr_phase = 1'b1;
    end else if (paddr == `OFS_MOD_CYCLE_SEL) begin
      wr_cycle = 1'b1;
    end
  end

  // Timing and rate; bit 31 is stored so software reads back what it
  // wrote there, although zero is the expected value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate <= 4'h0;
      second_output_edge_timing <= 16'h0000;
      bit31 <= 1'b0;
    end else if (wr_timing) begin
      rate <= pwdata[`RATE_MSB:`RATE_LSB];
      second_output_edge_timing <=
        pwdata[`TIMING_MSB:`TIMING_LSB];
      bit31 <= pwdata[`BIT31];
    end
  end

  // Phase shift value; bit 0 and the upper bits are not stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 16'h0000;
    end else if (wr_phase) begin
      phase <= pwdata[`PHASE_MSB:`PHASE_LSB];
    end
  end

  // Both cycle fields are held; bit 8 picks which one drives the rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modulation_cycle_select_a <= 3'h0;
      modulation_cycle_select_b <= 3'h0;
      cycle_sel_use_b <= 1'b0;
    end else if (wr_cycle) begin
      modulation_cycle_select_a <= pwdata[`CYC_A_MSB:`CYC_A_LSB];
      modulation_cycle_select_b <= pwdata[`CYC_B_MSB:`CYC_B_LSB];
      cycle_sel_use_b <= pwdata[`CYC_SEL_BIT];
    end
  end

  // --------------------------------------------------------------------
  // APB read mux, decoded during setup
  // --------------------------------------------------------------------
  // Unmapped addresses read zero and flag an error
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == `OFS_EDGE_TIMING_RATE) begin
      next_rdata = {bit31, 11'h000, second_output_edge_timing,
                    rate};
    end else if (paddr == `OFS_PHASE_SHIFT) begin
      next_rdata = {15'h0000, phase, 1'b0};
    end else if (paddr == `OFS_MOD_CYCLE_SEL) begin
      next_rdata = {23'h000000, cycle_sel_use_b, 1'b0,
                    modulation_cycle_select_b, 1'b0,
                    modulation_cycle_select_a};
    end else if (paddr == `OFS_WAVE_STATUS) begin
      next_rdata = {19'h00000, edge_delay, eff_rate, 4'h0,
                    wave_index};
    end else begin
      next_err = 1'b1;
    end
  end

  // Registered answer: pready rises one cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & next_err;
      if (rd_setup) begin
        prdata <= next_rdata;
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // --------------------------------------------------------------------
  // Modulation cycle tracking on the count clock
  // --------------------------------------------------------------------
  // A shorter cycle chosen mid-run can leave the index past its end;
  // comparing with >= folds it to zero on the next wave rather than
  // letting it climb to fifteen first
  assign cycle_wrap = (wave_index >= cycle_last);

  // Next wave position; the PPG mode does not gate it
  always @* begin
    next_wave_index = wave_index;
    if (wave_end) begin
      if (cycle_wrap) begin
        next_wave_index = 4'h0;
      end else begin
        next_wave_index = wave_index + 4'h1;
      end
    end
  end

  // Wave position register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_index <= 4'h0;
    end else begin
      wave_index <= next_wave_index;
    end
  end

  // --------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------
  // Delay flag for the wave now starting, both modes alike; it lags
  // the index by one clock, which the counter side must allow for
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_delay <= 1'b0;
    end else begin
      edge_delay <= stretch;
    end
  end

  // Phase shift only means something when interlocked; plain mode
  // sees zero so a stale value cannot shift the second output
  // (the stored value itself survives a change of mode)
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_shift_amount <= 16'h0000;
    end else if (interlock_mode) begin
      phase_shift_amount <= phase;
    end else begin
      phase_shift_amount <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

// *** hdl/rate_spreader.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ppg_rate_defs.vh"

// ----------------------------------------------------------------------
// Decides whether the current wave of a modulation cycle is stretched
// ----------------------------------------------------------------------
module rate_spreader (
  input wire [2:0] cycle_sel,
  input wire [3:0] rate,
  input wire [3:0] wave_index,
  output reg [3:0] eff_rate,
  output reg [3:0] cycle_last,
  output reg stretch
);
  reg [3:0] idx;
  reg [8:0] len;
  reg [8:0] hi;
  reg [8:0] lo;

  // Keep only the valid upper rate bits; unknown codes act like none
  always @* begin
    eff_rate = 4'h0;
    cycle_last = 4'h0;
    idx = 4'h0;
    case (cycle_sel)
      `CYC_2: begin
        eff_rate = {3'h0, rate[3]};
        cycle_last = 4'h1;
        idx = {3'h0, wave_index[0]};
      end
      `CYC_4: begin
        eff_rate = {2'h0, rate[3:2]};
        cycle_last = 4'h3;
        idx = {2'h0, wave_index[1:0]};
      end
      `CYC_8: begin
        eff_rate = {1'h0, rate[3:1]};
        cycle_last = 4'h7;
        idx = {1'h0, wave_index[2:0]};
      end
      `CYC_16: begin
        eff_rate = rate;
        cycle_last = 4'hf;
        idx = wave_index;
      end
      default: begin
        eff_rate = 4'h0;
      end
    endcase
    // Wave i is stretched when floor((i+1)r/N) passes floor(ir/N),
    // which spreads exactly r stretched waves over the N of a cycle;
    // nine bits hold 16 x 15 so the products never wrap
    len = {5'h00, cycle_last} + 9'h001;
    hi = ({5'h00, idx} + 9'h001) * {5'h00, eff_rate};
    lo = {5'h00, idx} * {5'h00, eff_rate};
    stretch = (hi / len) != (lo / len);
    if (eff_rate == 4'h0) begin
      stretch = 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** test/ppg_timing_rate_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppg_timing_rate_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic interlock_mode,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] second_output_edge_timing,
  input wire logic [15:0] phase_shift_amount,
  input wire logic edge_delay
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] rate_q;
  logic [15:0] tim_q;
  logic [8:0] cs_q;
  logic none_q;
  wire [2:0] code = cs_q[8] ? cs_q[6:4] : cs_q[2:0];
  wire wr_done = psel && penable && pready && pwrite;
  // Shadow of what software wrote, to judge reads against
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_q <= 4'h0;
      tim_q <= 16'h0;
      cs_q <= 9'h0;
      none_q <= 1'b1;
    end else begin
      none_q <= (code == 3'h0) || (code > 3'h4);
      if (wr_done && paddr == 12'h000) begin
        rate_q <= pwdata[3:0];
        tim_q <= pwdata[19:4];
      end
      if (wr_done && paddr == 12'h008) begin
        cs_q <= pwdata[8:0];
      end
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence done_s;
    psel && penable && pready;
  endsequence
  a_ready_next: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_timing_write: assert property (
    (done_s ##0 (pwrite && paddr == 12'h000))
    |=> second_output_edge_timing == tim_q)
    else $error("timing output not updated");
  a_read_fields: assert property (
    (done_s ##0 (!pwrite && paddr == 12'h000))
    |-> prdata[3:0] == rate_q && prdata[19:4] == tim_q)
    else $error("read fields wrong");
  a_read_zero: assert property (
    (done_s ##0 (!pwrite && paddr == 12'h000))
    |-> prdata[30:20] == 11'h0)
    else $error("reserved bits not zero");
  a_none_idle: assert property (none_q [*3] |-> !edge_delay)
    else $error("delay with no cycle");
  a_err_unmapped: assert property ((setup_s ##0 paddr > 12'h00c) |=> pslverr)
    else $error("no error on unmapped");
  a_phase_plain: assert property (!interlock_mode [*2]
    |-> phase_shift_amount == 16'h0)
    else $error("phase in plain mode");
endmodule
bind ppg_timing_rate ppg_timing_rate_props ppg_timing_rate_props_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .interlock_mode(interlock_mode),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .second_output_edge_timing(second_output_edge_timing),
  .phase_shift_amount(phase_shift_amount),
  .edge_delay(edge_delay)
);
`default_nettype wire

// *** test/ppg_timing_rate_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ppg_timing_rate_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic wave_end = 0, interlock_mode = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, edge_delay;
  wire [15:0] second_output_edge_timing, phase_shift_amount;
  int failures = 0, n_checks = 0;
  ppg_timing_rate ppg_timing_rate_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .wave_end(wave_end),
    .interlock_mode(interlock_mode),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .second_output_edge_timing(second_output_edge_timing),
    .phase_shift_amount(phase_shift_amount),
    .edge_delay(edge_delay)
  );
  initial forever #2 pclk = ~pclk;
  // ---------------------------------
  // Shared bus, wave and compare tasks
  // ---------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Idle edge first, so a release and a new setup never share a step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wave;
    @(posedge pclk);
    wave_end <= 1'b1;
    @(posedge pclk);
    wave_end <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task t_regs;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0);
    apb(1, 12'h000, 32'h8abc_def5);
    apb(0, 12'h000, 0);
    chk(rd, 32'h800c_def5);
    chk({16'h0, second_output_edge_timing}, 32'h0000_cdef);
    apb(1, 12'h010, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(0, 12'h000, 0);
    chk(rd, 32'h800c_def5);
    apb(0, 12'h010, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // Rate 0xb, so masked low bits show up if wrongly counted
  task t_rate(input logic [2:0] c, input logic b, input logic il,
              input int n, input logic [3:0] eff);
    int cnt;
    cnt = 0;
    interlock_mode <= il;
    apb(1, 12'h008, b ? {23'h0, 1'b1, 1'b0, c, 4'h0}
                      : {25'h0, 3'h4, 1'b0, c});
    apb(0, 12'h00c, 0);
    chk({28'h0, rd[11:8]}, {28'h0, eff});
    repeat (n) begin
      wave;
      if (edge_delay === 1'b1) cnt++;
    end
    chk(cnt, {28'h0, eff});
  endtask
  // Phase value reaches the output only while interlocked
  task t_phase;
    apb(1, 12'h004, 32'hfffe_579b);
    apb(0, 12'h004, 0);
    chk(rd, 32'h0000_579a);
    interlock_mode <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({16'h0, phase_shift_amount}, 32'h0000_2bcd);
    interlock_mode <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({16'h0, phase_shift_amount}, 32'h0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_phase;
    apb(1, 12'h000, 32'h0001_234b);
    t_rate(3'h0, 0, 0, 4, 4'h0);
    t_rate(3'h1, 0, 0, 2, 4'h1);
    t_rate(3'h2, 0, 1, 4, 4'h2);
    t_rate(3'h3, 0, 0, 8, 4'h5);
    t_rate(3'h4, 0, 1, 16, 4'hb);
    t_rate(3'h4, 1, 0, 16, 4'hb);
    t_rate(3'h5, 0, 0, 4, 4'h0);
    results;
  end
  initial begin
    #40000;
    failures++;
    results;
  end
endmodule
`default_nettype wire
